// ==== rtl/alc_pkg.sv ====
package alc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ALC_OFS_MODE    = 7'h7b;
  localparam logic [6:0] ALC_OFS_THRESH  = 7'h7c;
  localparam logic [6:0] ALC_OFS_RESTART = 7'h7d;
  localparam logic [7:0] ALC_MODE_RST    = 8'h00;
  localparam logic [7:0] ALC_THRESH_RST  = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ALC_POS_ENABLE   = 0;
  localparam int ALC_POS_DUAL     = 1;
  localparam int ALC_POS_RECSEL   = 2;
  localparam int ALC_POS_STEPLIM  = 4;
  localparam int ALC_POS_RATE     = 6;
  localparam int ALC_POS_ATTACK_INTERVAL  = 0;
  localparam int ALC_POS_RECOVERY_INTERVAL  = 1;
  localparam int ALC_POS_ATTACK_THRESHOLD    = 3;
  localparam int ALC_POS_RECOVERY_THRESHOLD    = 5;

  // ----------------------------------------------------------------
  // codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] ALC_REC_NONE    = 2'h0;
  localparam logic [1:0] ALC_REC_NORMAL  = 2'h1;
  localparam logic [1:0] ALC_REC_LIMITED = 2'h2;
  localparam logic [1:0] ALC_RATE_96K    = 2'h0;
  localparam logic [1:0] ALC_RATE_48K    = 2'h1;
  localparam logic [1:0] ALC_RATE_32K    = 2'h2;
  localparam int ALC_KHZ_96        = 96;
  localparam int ALC_KHZ_48        = 48;
  localparam int ALC_KHZ_32        = 32;
  localparam int ALC_ATK_SHORT_MS  = 1;
  localparam int ALC_ATK_LONG_MS   = 4;
  localparam int ALC_REC_BASE_MS   = 32;
  localparam logic [7:0] ALC_GAIN_MAX = 8'hff;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [5:0] left;
    logic [5:0] right;
  } alc_levels_t;

  typedef struct packed {
    logic [6:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } alc_reg_req_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  thresh;
    logic [7:0]  gain_red;
    logic [15:0] atk_cnt;
    logic [15:0] rec_cnt;
    logic [4:0]  steps;
    logic [7:0]  rdata;
  } alc_state_t;

endpackage : alc_pkg

// ==== rtl/alc_level_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

// Function
// RQ1 - level control acts only while enable bit is set; otherwise gain untouched (a restart write still clears gain to 0 while disabled)
// RQ2 - dual detect 0: either channel over attack limit starts gain reduction
// RQ3 - dual detect 1: reduce only when both channels are over together
// RQ4 - recovery select: 00 none, 01 normal, 10 limited, 11 reserved
// RQ5 - limited recovery step limit codes give 3, 7, 15, 31
// RQ6 - software sets rate field to the adc rate; code 11 not used
// RQ7 - recovery threshold codes give -2, -3, -4, -6 dB
// RQ8 - attack threshold codes give 0, -1, -2, -4 dB
// RQ9 - recovery interval codes give 32, 64, 128, 256 ms
// RQ10 - attack interval bit gives 1 ms or 4 ms
// RQ11 - any write to third register restarts level control
// RQ12 - reading third register returns current gain reduction
// RQ13 - intervals counted in adc sample periods at the selected rate
// RQ14 - limited recovery stops after the step limit until restart
module alc_level_ctrl (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire alc_pkg::alc_reg_req_t reg_req_i,
  output logic [7:0]                 reg_rdata_o,
  input  wire logic                  sample_stb_i,
  input  wire alc_pkg::alc_levels_t  levels_i,
  output logic [7:0]                 gain_reduction_o
);
  import alc_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rate_khz(input logic [1:0] code);
    unique case (code)
      ALC_RATE_96K: rate_khz = 16'(ALC_KHZ_96);
      ALC_RATE_32K: rate_khz = 16'(ALC_KHZ_32);
      default:      rate_khz = 16'(ALC_KHZ_48);
    endcase
  endfunction : rate_khz

  function automatic logic [5:0] atk_db(input logic [1:0] code);
    atk_db = (code == 2'h3) ? 6'h04 : {4'h0, code};                     // see RQ8
  endfunction : atk_db

  function automatic logic [5:0] rec_db(input logic [1:0] code);
    rec_db = (code == 2'h3) ? 6'h06 : 6'(code) + 6'h02;                 // see RQ7
  endfunction : rec_db

  alc_state_t  s_q;
  alc_state_t  s_d;
  logic        enable;
  logic        dual;
  logic [1:0]  recsel;
  logic [4:0]  step_lim;
  logic [15:0] khz;
  logic [15:0] atk_lim;
  logic [15:0] rec_lim;
  logic        l_over;
  logic        r_over;
  logic        over;
  logic        quiet;
  logic        may_recover;
  logic        restart;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    enable   = s_q.mode[ALC_POS_ENABLE];
    dual     = s_q.mode[ALC_POS_DUAL];
    recsel   = s_q.mode[ALC_POS_RECSEL +: 2];
    step_lim = 5'((6'h04 << s_q.mode[ALC_POS_STEPLIM +: 2]) - 6'h01);   // see RQ5
    khz      = rate_khz(s_q.mode[ALC_POS_RATE +: 2]);                    // see RQ13
    atk_lim  = 16'(khz * (s_q.thresh[ALC_POS_ATTACK_INTERVAL] ?
                          ALC_ATK_LONG_MS : ALC_ATK_SHORT_MS));          // see RQ10
    rec_lim  = 16'(khz * (ALC_REC_BASE_MS << s_q.thresh[ALC_POS_RECOVERY_INTERVAL +: 2])); // see RQ9
    l_over   = levels_i.left  <= atk_db(s_q.thresh[ALC_POS_ATTACK_THRESHOLD +: 2]);
    r_over   = levels_i.right <= atk_db(s_q.thresh[ALC_POS_ATTACK_THRESHOLD +: 2]);
    over     = dual ? (l_over & r_over) : (l_over | r_over);            // see RQ2 see RQ3
    quiet    = (levels_i.left  >= rec_db(s_q.thresh[ALC_POS_RECOVERY_THRESHOLD +: 2])) &&
               (levels_i.right >= rec_db(s_q.thresh[ALC_POS_RECOVERY_THRESHOLD +: 2]));
    may_recover = (recsel == ALC_REC_NORMAL) ||
                  ((recsel == ALC_REC_LIMITED) && (s_q.steps < step_lim)); // see RQ4 see RQ14
    restart  = reg_req_i.wr && (reg_req_i.addr == ALC_OFS_RESTART);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (reg_req_i.wr && reg_req_i.addr == ALC_OFS_MODE) begin
      s_d.mode = reg_req_i.wdata;
    end
    if (reg_req_i.wr && reg_req_i.addr == ALC_OFS_THRESH) begin
      s_d.thresh = {1'b0, reg_req_i.wdata[6:0]};
    end
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        ALC_OFS_MODE:    s_d.rdata = s_q.mode;
        ALC_OFS_THRESH:  s_d.rdata = s_q.thresh;
        ALC_OFS_RESTART: s_d.rdata = s_q.gain_red;                     // see RQ12
        default:         s_d.rdata = 8'h00;
      endcase
    end
    if (restart) begin                                                  // see RQ11
      s_d.gain_red = 8'h00;
      s_d.atk_cnt  = 16'h0000;
      s_d.rec_cnt  = 16'h0000;
      s_d.steps    = 5'h00;
    end else if (enable && sample_stb_i) begin                          // see RQ1
      if (over) begin
        s_d.rec_cnt = 16'h0000;
        if (s_q.atk_cnt >= atk_lim - 16'h0001) begin
          s_d.atk_cnt = 16'h0000;
          if (s_q.gain_red != ALC_GAIN_MAX) begin
            s_d.gain_red = s_q.gain_red + 8'h01;
          end
        end else begin
          s_d.atk_cnt = s_q.atk_cnt + 16'h0001;
        end
      end else begin
        s_d.atk_cnt = 16'h0000;
        if (quiet && may_recover && s_q.gain_red != 8'h00) begin
          if (s_q.rec_cnt >= rec_lim - 16'h0001) begin
            s_d.rec_cnt  = 16'h0000;
            s_d.gain_red = s_q.gain_red - 8'h01;
            if (s_q.steps != 5'h1f) begin
              s_d.steps = s_q.steps + 5'h01;                            // see RQ14
            end
          end else begin
            s_d.rec_cnt = s_q.rec_cnt + 16'h0001;
          end
        end else begin
          s_d.rec_cnt = 16'h0000;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '{mode: ALC_MODE_RST, thresh: ALC_THRESH_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_o      = s_q.rdata;
  assign gain_reduction_o = s_q.gain_red;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence attack_due;
    enable && sample_stb_i && !restart && s_q.atk_cnt == atk_lim - 16'h0001 &&
      s_q.gain_red != ALC_GAIN_MAX;
  endsequence

  sequence recover_due;
    enable && sample_stb_i && !restart && !over && quiet && may_recover &&
      s_q.gain_red != 8'h00 && s_q.rec_cnt == rec_lim - 16'h0001;
  endsequence

  a_disabled_gain_hold: assert property (                                    // see RQ1
    !enable && !restart |=> gain_reduction_o == $past(gain_reduction_o))
    else $error("gain moved while disabled");
  a_either_attack_step: assert property (                                    // see RQ2
    attack_due ##0 (!dual && (l_over || r_over)) |=>
      gain_reduction_o == $past(gain_reduction_o) + 8'h01)
    else $error("single channel over did not reduce gain");
  a_both_attack_only: assert property (                                      // see RQ3
    enable && sample_stb_i && dual && (l_over != r_over) && !restart |=>
      gain_reduction_o <= $past(gain_reduction_o))
    else $error("one channel reduced gain in dual mode");
  a_no_recovery_mode: assert property (                                      // see RQ4
    recsel == ALC_REC_NONE && !restart |=> gain_reduction_o >= $past(gain_reduction_o))
    else $error("gain recovered with recovery off");
  a_limit_stops_rec: assert property (                                       // see RQ14
    recsel == ALC_REC_LIMITED && s_q.steps == step_lim && !restart |=>
      gain_reduction_o >= $past(gain_reduction_o))
    else $error("recovery past step limit");
  a_rec_needs_quiet: assert property (                                       // see RQ7
    !restart && !quiet |=> gain_reduction_o >= $past(gain_reduction_o))
    else $error("recovery above recovery threshold");
  a_attack_cnt_bound: assert property (                                      // see RQ13
    enable && sample_stb_i && !restart && !reg_req_i.wr |=>
      s_q.atk_cnt < atk_lim)
    else $error("attack counter beyond interval");
  a_restart_clears: assert property (                                        // see RQ11
    restart |=> gain_reduction_o == 8'h00 && s_q.steps == 5'h00)
    else $error("restart did not clear gain");
  a_read_gain_value: assert property (                                       // see RQ12
    reg_req_i.rd && reg_req_i.addr == ALC_OFS_RESTART |=>
      reg_rdata_o == $past(gain_reduction_o))
    else $error("gain read mismatch");
  a_quiet_recover_step: assert property (                                    // see RQ9
    recover_due |=> gain_reduction_o == $past(gain_reduction_o) - 8'h01)
    else $error("quiet interval did not recover gain");
  a_recover_step_count: assert property (                                    // see RQ14
    recover_due ##0 s_q.steps != 5'h1f |=> s_q.steps == $past(s_q.steps) + 5'h01)
    else $error("recovery step not counted");
  a_dual_attack_step: assert property (                                      // see RQ3
    attack_due ##0 (dual && l_over && r_over) |=>
      gain_reduction_o == $past(gain_reduction_o) + 8'h01)
    else $error("both channels over did not reduce gain");
  a_over_clears_rec: assert property (                                       // see RQ13
    enable && sample_stb_i && !restart && over |=> s_q.rec_cnt == 16'h0000)
    else $error("recovery count kept during attack");
  a_read_mode_value: assert property (                                       // see RQ1
    reg_req_i.rd && reg_req_i.addr == ALC_OFS_MODE |=> reg_rdata_o == $past(s_q.mode))
    else $error("mode read mismatch");
  a_thresh_top_zero: assert property (                                       // see RQ7
    reg_req_i.wr && reg_req_i.addr == ALC_OFS_THRESH |=> s_q.thresh[7] == 1'b0)
    else $error("reserved threshold bit stored");

endmodule : alc_level_ctrl

`default_nettype wire

// ==== verification/alc_adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------
// adc sample source
// ------
module alc_adc_model (
  input  wire logic           clk_i,
  output logic                sample_stb_o,
  output alc_pkg::alc_levels_t levels_o
);
  import alc_pkg::*;
  initial begin
    sample_stb_o = 1'b0;
    levels_o     = '1;
  end
  // n back-to-back strobes, levels garbled after the last one
  task automatic burst(input int n, input logic [5:0] l, input logic [5:0] r);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      #1;
      sample_stb_o = 1'b1;
      levels_o     = {l, r};
    end
    @(posedge clk_i);
    #1;
    sample_stb_o = 1'b0;
    levels_o     = ~{l, r};
  endtask : burst
endmodule : alc_adc_model
`default_nettype wire

// ==== verification/tb_auto_record_level_control.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_auto_record_level_control;
  import alc_pkg::*;
  logic         clk_i;
  logic         rst_i;
  alc_reg_req_t reg_req_i;
  logic [7:0]   reg_rdata_o;
  logic         sample_stb_i;
  alc_levels_t  levels_i;
  logic [7:0]   gain_reduction_o;
  int           errors;
  int           checked;
  int           atk_db [4] = '{0, 1, 2, 4};
  alc_level_ctrl i_alc_level_ctrl (.clk_i(clk_i), .rst_i(rst_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .sample_stb_i(sample_stb_i), .levels_i(levels_i),
    .gain_reduction_o(gain_reduction_o));
  alc_adc_model i_alc_adc_model (.clk_i(clk_i), .sample_stb_o(sample_stb_i), .levels_o(levels_i));
  // ------
  // helpers
  // ------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic req(input logic [6:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_req_i = '{addr: a, wr: w, rd: ~w, wdata: d};
    @(posedge clk_i);
    #1;
    reg_req_i = '0;
  endtask : req
  task automatic chk_reg(input logic [6:0] a, input logic [7:0] e);
    req(a, 1'b0, 8'h00);
    check(reg_rdata_o, e);
  endtask : chk_reg
  task automatic gain_is(input logic [7:0] e);
    @(posedge clk_i);
    #1;
    check(gain_reduction_o, e);
  endtask : gain_is
  task automatic burst(input int n, input logic [5:0] l, input logic [5:0] r);
    i_alc_adc_model.burst(n, l, r);
  endtask : burst
  task automatic step(input int n, input logic [5:0] l, input logic [5:0] r,
                      input logic [7:0] g0, input logic [7:0] g1);
    burst(n - 1, l, r);
    gain_is(g0);
    burst(1, l, r);
    gain_is(g1);
  endtask : step
  task automatic setup(input logic [7:0] mode, input logic [7:0] th);
    req(ALC_OFS_RESTART, 1'b1, 8'h00);
    req(ALC_OFS_THRESH, 1'b1, th);
    req(ALC_OFS_MODE, 1'b1, mode);
  endtask : setup
  task automatic complete_run;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  // ------
  // scenarios
  // ------
  task automatic t_regs;
    chk_reg(ALC_OFS_MODE, ALC_MODE_RST);
    req(ALC_OFS_THRESH, 1'b1, 8'hff);
    chk_reg(ALC_OFS_THRESH, 8'h7f);
    chk_reg(7'h00, 8'h00);
    $display("registers done");
  endtask : t_regs
  task automatic t_attack;
    setup(8'h01, 8'h00);
    step(96, 6'd0, 6'd63, 8'h00, 8'h01);
    chk_reg(ALC_OFS_RESTART, 8'h01);
    req(ALC_OFS_MODE, 1'b1, 8'h03);
    burst(150, 6'd0, 6'd63);
    gain_is(8'h01);
    step(96, 6'd0, 6'd0, 8'h01, 8'h02);
    req(ALC_OFS_MODE, 1'b1, 8'h02);
    burst(200, 6'd0, 6'd0);
    gain_is(8'h02);
    req(ALC_OFS_RESTART, 1'b1, 8'h5a);
    gain_is(8'h00);
    setup(8'h41, 8'h01);
    step(4 * 48, 6'd0, 6'd63, 8'h00, 8'h01);
    for (int k = 0; k < 4; k++) begin
      setup(8'h01, 8'(k << ALC_POS_ATTACK_THRESHOLD));
      burst(96, 6'(atk_db[k] + 1), 6'd63);
      gain_is(8'h00);
      step(96, 6'(atk_db[k]), 6'd63, 8'h00, 8'h01);
    end
    $display("attack done");
  endtask : t_attack
  task automatic t_recover;
    setup(8'h85, 8'h00);
    step(32, 6'd0, 6'd63, 8'h00, 8'h01);
    burst(1100, 6'd1, 6'd2);
    gain_is(8'h01);
    step(32 * 32, 6'd2, 6'd2, 8'h01, 8'h00);
    req(ALC_OFS_THRESH, 1'b1, 8'h62);
    burst(32, 6'd0, 6'd63);
    burst(2100, 6'd5, 6'd5);
    gain_is(8'h01);
    step(64 * 32, 6'd6, 6'd6, 8'h01, 8'h00);
    for (int m = 0; m < 2; m++) begin
      req(ALC_OFS_MODE, 1'b1, 8'h81 | 8'(m * 12));
      burst(32, 6'd0, 6'd63);
      burst(2100, 6'd6, 6'd6);
      gain_is(8'(m + 1));
    end
    setup(8'h09, 8'h00);
    burst(480, 6'd0, 6'd63);
    gain_is(8'h05);
    burst(3 * 3072, 6'd2, 6'd2);
    gain_is(8'h02);
    burst(3082, 6'd2, 6'd2);
    gain_is(8'h02);
    $display("recovery done");
  endtask : t_recover
  initial begin
    #3_000_000;
    errors++;
    $display("Error %0t: watchdog", $time);
    complete_run;
  end
  initial begin
    errors    = 0;
    checked   = 0;
    rst_i     = 1'b1;
    reg_req_i = '0;
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    t_regs;
    t_attack;
    t_recover;
    complete_run;
  end
endmodule : tb_auto_record_level_control
`default_nettype wire
